// >>> logic/rvt_pkg.sv
// ring validation timing: shared constants, register map and state codes
// assumes a 10 MHz clock and a 2 ms base tick made from it
`default_nettype none
package rvt_pkg;

	// ==========================================================
	// clock and timing base
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TICK_PERIOD_NS = 2_000_000;
	localparam int TICK_MS        = 2;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CNT_W          = 10;
	localparam int FREQ_W         = 6;

	// ==========================================================
	// register offsets and reset values
	localparam logic [7:0] OFF_CTRL1 = 8'h16;
	localparam logic [7:0] OFF_CTRL2 = 8'h17;
	localparam logic [7:0] OFF_CTRL3 = 8'h18;
	localparam logic [7:0] OFF_STAT  = 8'h40;
	localparam logic [7:0] RST_CTRL1 = 8'h00;
	localparam logic [7:0] RST_CTRL2 = 8'h2d;
	localparam logic [7:0] RST_CTRL3 = 8'h19;

	// ==========================================================
	// field positions
	localparam int DLY_LO_MSB = 7;
	localparam int DLY_LO_LSB = 6;
	localparam int MAXF_MSB   = 5;
	localparam int DLY_HI_BIT = 7;
	localparam int END_TO_MSB = 6;
	localparam int END_TO_LSB = 3;
	localparam int CONF_MSB   = 2;
	localparam int EN_BIT     = 7;
	localparam int RSVD_BIT   = 6;
	localparam int MINF_MSB   = 5;

	// ==========================================================
	// time steps and confirmation table, in ms
	localparam int DLY_STEP_MS = 256;
	localparam int END_STEP_MS = 128;
	localparam int CONF_MS_0   = 100;
	localparam int CONF_MS_1   = 150;
	localparam int CONF_MS_2   = 200;
	localparam int CONF_MS_3   = 256;
	localparam int CONF_MS_4   = 384;
	localparam int CONF_MS_5   = 512;
	localparam int CONF_MS_6   = 640;
	localparam int CONF_MS_7   = 1024;

	// ==========================================================
	// qualifier states
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_CONFIRM = 4'h2,
		ST_DELAY   = 4'h4,
		ST_VALID   = 4'h8
	} rvt_state_t;

endpackage
`default_nettype wire

// >>> logic/rvt_qual_if.sv
// ring validation timing: carrier between the qualifier and its timer
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface rvt_qual_if;
	logic       tick;
	logic       load;
	logic [5:0] load_val;
	logic [5:0] count;
	logic       expired;

	modport timer (input tick, input load, input load_val,
		output count, output expired);
	modport ctrl (output tick, output load, output load_val,
		input count, input expired);
endinterface
`default_nettype wire

// >>> logic/rvt_tick_div.sv
// ring validation timing: base tick divider
// assumes clk is the only clock; tick is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module rvt_tick_div #(
	parameter int CYCLES = rvt_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// enable out
	output logic      tick
);
	localparam int W = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_q;

	// ==========================================================
	// free running count, wraps once per tick period
	always_ff @(posedge clk) begin
		if (rst || cnt_q == LAST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	assign tick = (cnt_q == LAST);
endmodule
`default_nettype wire

// >>> logic/rvt_qual_timer.sv
// ring validation timing: downcounting frequency qualification timer
// assumes load and tick come from the qualifier on the same clock
`timescale 1ns/1ps
`default_nettype none
module rvt_qual_timer (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// qualifier side
	rvt_qual_if.timer q
);
	logic [5:0] cnt_q;

	// ==========================================================
	// load wins over tick so an event always restarts the window
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (q.load) begin
			cnt_q <= q.load_val;
		end else if (q.tick && cnt_q != '0) begin
			cnt_q <= cnt_q - 6'h1;
		end
	end

	assign q.count   = cnt_q;
	assign q.expired = (cnt_q == '0); // holds at zero until reloaded
endmodule
`default_nettype wire

// >>> logic/rvt_ring_validate.sv
// ring validation timing: qualifier, confirmation, delay and ring end
// assumes ring_event is a one-cycle pulse per tip/ring threshold crossing
`timescale 1ns/1ps
`default_nettype none
module rvt_ring_validate #(
	parameter int TICK_CYCLES = rvt_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_we,
	input  wire logic       reg_re,
	output logic      [7:0] reg_rdata,
	// line side events and mode
	input  wire logic       ring_event,
	input  wire logic       low_power,
	// indications
	output logic            ring_valid,
	output logic            ring_end
);
	localparam int CW = rvt_pkg::CNT_W;

	// ==========================================================
	// time code decoding, all results in base ticks
	function automatic logic [CW-1:0] ms_ticks(input int ms);
		ms_ticks = CW'(ms / rvt_pkg::TICK_MS);
	endfunction

	function automatic logic [CW-1:0] conf_ticks(input logic [2:0] c);
		case (c)
			3'h0:    conf_ticks = ms_ticks(rvt_pkg::CONF_MS_0);
			3'h1:    conf_ticks = ms_ticks(rvt_pkg::CONF_MS_1);
			3'h2:    conf_ticks = ms_ticks(rvt_pkg::CONF_MS_2);
			3'h3:    conf_ticks = ms_ticks(rvt_pkg::CONF_MS_3);
			3'h4:    conf_ticks = ms_ticks(rvt_pkg::CONF_MS_4);
			3'h5:    conf_ticks = ms_ticks(rvt_pkg::CONF_MS_5);
			3'h6:    conf_ticks = ms_ticks(rvt_pkg::CONF_MS_6);
			default: conf_ticks = ms_ticks(rvt_pkg::CONF_MS_7);
		endcase
	endfunction

	// ==========================================================
	// configuration registers
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl3_q;
	logic [7:0] rdata_q;

	// reserved bit 6 of the enable register is forced to zero
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl1_q <= rvt_pkg::RST_CTRL1;
			ctrl2_q <= rvt_pkg::RST_CTRL2;
			ctrl3_q <= rvt_pkg::RST_CTRL3;
		end else if (reg_we) begin
			if (reg_addr == rvt_pkg::OFF_CTRL1) begin
				ctrl1_q <= reg_wdata;
			end
			if (reg_addr == rvt_pkg::OFF_CTRL2) begin
				ctrl2_q <= reg_wdata;
			end
			if (reg_addr == rvt_pkg::OFF_CTRL3) begin
				ctrl3_q <= reg_wdata & ~(8'h1 << rvt_pkg::RSVD_BIT);
			end
		end
	end

	// ==========================================================
	// field extraction
	logic [2:0]          dly_code;
	logic [3:0]          tmo_code;
	logic [2:0]          cnf_code;
	logic                qual_en;
	logic [5:0]          minf_lim;
	logic [5:0]          maxf_lim;
	logic [CW-1:0]       dly_t;
	logic [CW-1:0]       tmo_t;
	logic [CW-1:0]       conf_t;

	assign dly_code = {ctrl2_q[rvt_pkg::DLY_HI_BIT],
		ctrl1_q[rvt_pkg::DLY_LO_MSB:rvt_pkg::DLY_LO_LSB]};
	assign tmo_code = ctrl2_q[rvt_pkg::END_TO_MSB:rvt_pkg::END_TO_LSB];
	assign cnf_code = ctrl2_q[rvt_pkg::CONF_MSB:0];
	assign qual_en  = ctrl3_q[rvt_pkg::EN_BIT];
	assign minf_lim = ctrl3_q[rvt_pkg::MINF_MSB:0];
	assign maxf_lim = ctrl1_q[rvt_pkg::MAXF_MSB:0];
	// delay is linear in 256 ms steps; covers every listed code
	assign dly_t  = CW'(dly_code) * ms_ticks(rvt_pkg::DLY_STEP_MS);
	// a zero timeout code is treated as one step so the ring can end
	assign tmo_t  = CW'((tmo_code == 4'h0) ? 4'h1 : tmo_code)
		* ms_ticks(rvt_pkg::END_STEP_MS);
	assign conf_t = conf_ticks(cnf_code);

	// ==========================================================
	// base tick and frequency timer
	logic tick;
	rvt_qual_if q ();

	rvt_tick_div #(
		.CYCLES (TICK_CYCLES)
	) rvt_tick_div_i (
		.clk  (clk),
		.rst  (rst),
		.tick (tick)
	);

	rvt_qual_timer rvt_qual_timer_i (
		.clk (clk),
		.rst (rst),
		.q   (q.timer)
	);

	// every crossing reloads while qualification is enabled; the timer runs at the fixed 2 ms rate
	assign q.tick     = tick;
	assign q.load     = ring_event && qual_en;
	assign q.load_val = minf_lim;

	// ==========================================================
	// spacing check on a following crossing
	logic too_low;
	logic too_high;
	logic bad_event;

	// spacing accepted is min limit minus max limit up to min limit minus one ticks
	assign too_low   = q.expired;
	assign too_high  = (q.count > maxf_lim);
	assign bad_event = ring_event && qual_en && (too_low || too_high);

	// ==========================================================
	// state, phase counter and end-of-ring counter
	rvt_pkg::rvt_state_t state_q;
	rvt_pkg::rvt_state_t state_d;
	logic [CW-1:0]       phase_q;
	logic                phase_clr;
	logic [CW-1:0]       end_q;
	logic                end_hit;
	logic                conf_done;
	logic                dly_done;

	// low_power does not change qualification; both modes behave alike
	assign end_hit   = (state_q != rvt_pkg::ST_IDLE) && !ring_event
		&& (end_q >= tmo_t);
	assign conf_done = (phase_q >= conf_t);
	assign dly_done  = (phase_q >= dly_t);

	always_comb begin
		state_d = state_q;
		case (state_q)
			rvt_pkg::ST_IDLE: begin
				if (ring_event) begin
					state_d = qual_en ? rvt_pkg::ST_CONFIRM
						: rvt_pkg::ST_VALID;
				end
			end
			rvt_pkg::ST_CONFIRM: begin
				if (end_hit) begin
					state_d = rvt_pkg::ST_IDLE;
				end else if (!bad_event && conf_done) begin
					state_d = rvt_pkg::ST_DELAY;
				end
			end
			rvt_pkg::ST_DELAY: begin
				if (end_hit) begin
					state_d = rvt_pkg::ST_IDLE;
				end else if (bad_event) begin
					state_d = rvt_pkg::ST_CONFIRM;
				end else if (dly_done) begin
					state_d = rvt_pkg::ST_VALID;
				end
			end
			rvt_pkg::ST_VALID: begin
				if (end_hit) begin
					state_d = rvt_pkg::ST_IDLE;
				end else if (bad_event) begin
					state_d = rvt_pkg::ST_CONFIRM;
				end
			end
			default: state_d = rvt_pkg::ST_IDLE;
		endcase
	end

	// phase restarts on every state change and on any bad spacing
	assign phase_clr = (state_d != state_q) || bad_event;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= rvt_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// counters saturate so a stalled line cannot wrap them
	always_ff @(posedge clk) begin
		if (rst || phase_clr) begin
			phase_q <= '0;
		end else if (tick && phase_q != '1) begin
			phase_q <= phase_q + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst || ring_event) begin
			end_q <= '0;
		end else if (tick && end_q != '1) begin
			end_q <= end_q + CW'(1);
		end
	end

	// ==========================================================
	// indications and read data
	logic       ring_valid_q;
	logic       ring_end_q;
	logic [7:0] stat;

	always_ff @(posedge clk) begin
		if (rst) begin
			ring_valid_q <= 1'b0;
			ring_end_q   <= 1'b0;
		end else begin
			ring_valid_q <= (state_d == rvt_pkg::ST_VALID);
			ring_end_q   <= end_hit;
		end
	end

	assign stat = {low_power, 3'h0, state_q};

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (reg_re) begin
			case (reg_addr)
				rvt_pkg::OFF_CTRL1: rdata_q <= ctrl1_q;
				rvt_pkg::OFF_CTRL2: rdata_q <= ctrl2_q;
				rvt_pkg::OFF_CTRL3: rdata_q <= ctrl3_q;
				rvt_pkg::OFF_STAT:  rdata_q <= stat;
				default:            rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata  = rdata_q;
	assign ring_valid = ring_valid_q;
	assign ring_end   = ring_end_q;

	// ==========================================================
	// checks
	a_timer_reload: assert property (@(posedge clk) disable iff (rst)
		ring_event && qual_en |=> q.count == $past(minf_lim))
		else $error("timer not loaded with min limit");
	a_timer_step: assert property (@(posedge clk) disable iff (rst)
		tick && !q.load && q.count != 6'h0
		|=> q.count == $past(q.count) - 6'h1)
		else $error("timer did not decrement");
	a_low_invalid: assert property (@(posedge clk) disable iff (rst)
		state_q == rvt_pkg::ST_CONFIRM && ring_event && qual_en
		&& q.expired |=> state_q != rvt_pkg::ST_DELAY && phase_q == '0)
		else $error("slow ring not invalidated");
	a_high_invalid: assert property (@(posedge clk) disable iff (rst)
		state_q == rvt_pkg::ST_VALID && ring_event && qual_en
		&& q.count > maxf_lim |=> !ring_valid)
		else $error("fast ring not invalidated");
	a_confirm_done: assert property (@(posedge clk) disable iff (rst)
		state_q == rvt_pkg::ST_CONFIRM && !end_hit && !bad_event
		&& phase_q >= conf_t |=> state_q == rvt_pkg::ST_DELAY)
		else $error("confirmed ring did not advance");
	a_no_early_valid: assert property (@(posedge clk)
		disable iff (rst)
		$rose(ring_valid) && qual_en |-> $past(state_q) == rvt_pkg::ST_DELAY
		&& $past(phase_q) >= $past(dly_t))
		else $error("ring valid before delay elapsed");
	a_bypass_valid: assert property (@(posedge clk) disable iff (rst)
		state_q == rvt_pkg::ST_IDLE && ring_event && !qual_en
		|=> ring_valid && state_q == rvt_pkg::ST_VALID)
		else $error("bypass did not indicate ring");
	a_ring_over: assert property (@(posedge clk) disable iff (rst)
		state_q != rvt_pkg::ST_IDLE && !ring_event && end_q >= tmo_t
		|=> state_q == rvt_pkg::ST_IDLE ##0 ring_end ##1 !ring_end)
		else $error("ring end not declared on timeout");
	a_end_held_off: assert property (@(posedge clk) disable iff (rst)
		ring_event |=> !ring_end)
		else $error("ring end despite fresh crossing");
	a_timeout_scale: assert property (@(posedge clk)
		disable iff (rst) tmo_code != 4'h0
		|-> tmo_t == CW'(tmo_code)
		* CW'(rvt_pkg::END_STEP_MS / rvt_pkg::TICK_MS))
		else $error("timeout scaling wrong");
endmodule
`default_nettype wire

// >>> verif/rvt_line_model.sv
// line-side model: ring threshold crossings as one-cycle pulses
// assumes the bench calls burst from its main process at a falling edge
`timescale 1ns/1ps
`default_nettype none
module rvt_line_model (
	// clock
	input  wire logic clk,
	// crossings toward the validator
	output logic      ring_event
);
	// ==========================================================
	// crossing generator
	// the line idles low between crossings, it is never left floating
	initial begin
		ring_event = 1'b0;
	end

	// n crossings sp clocks apart; returns one clock after the last
	task automatic burst(input int n, input int sp);
		for (int i = 0; i < n; i++) begin
			if (i > 0)
				repeat (sp - 1) @(negedge clk);
			ring_event = 1'b1;
			@(negedge clk);
			ring_event = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> verif/rvt_ring_validate_tb.sv
// ring validation timing: self-checking bench for the validator
// assumes a short tick divider (TC clocks per 2 ms tick) in simulation
`timescale 1ns/1ps
`default_nettype none
module rvt_ring_validate_tb;
	// ==========================================================
	// stimulus and wiring
	localparam int TC = 10;
	logic       clk = 1'b0;
	logic       rst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_we;
	logic       reg_re;
	logic [7:0] reg_rdata;
	logic       ring_event;
	logic       low_power;
	logic       ring_valid;
	logic       ring_end;
	int         error_cnt = 0;
	int         n_compared = 0;

	// 100 ns period
	always #50 clk = ~clk;

	rvt_ring_validate #(.TICK_CYCLES(TC)) rvt_ring_validate_i (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.ring_event(ring_event), .low_power(low_power),
		.ring_valid(ring_valid), .ring_end(ring_end));
	rvt_line_model rvt_line_model_i (.clk(clk), .ring_event(ring_event));

	// ==========================================================
	// compare and bus tasks
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: read %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: flag %b expected %b", $time, g, e);
		end
	endtask

	// timing spans are bench counts, never design values
	task automatic chk_span(input int g, input int lo, input int hi);
		n_compared++;
		if (g < lo || g > hi) begin
			error_cnt++;
			$display("Error %0t: %0d clocks not in %0d..%0d", $time, g, lo, hi);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(negedge clk);
		reg_we = 1'b0;
	endtask

	// data is registered, so look one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_re = 1'b1;
		@(negedge clk);
		reg_re = 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// crossings every sp ticks; valid expected ex ticks after the first
	task automatic run_valid(input int n, input int sp, input int ex);
		int t;
		t = 0;
		fork
			rvt_line_model_i.burst(n, sp * TC);
			while (ring_valid !== 1'b1 && t < (ex + 9) * TC) begin
				@(negedge clk);
				t++;
			end
		join
		chk_span(t, (ex - 3) * TC, (ex + 3) * TC);
	endtask

	// crossings that must never qualify
	task automatic run_none(input int n, input int sp);
		logic seen;
		seen = 1'b0;
		fork
			rvt_line_model_i.burst(n, sp * TC);
			repeat (n * sp * TC) begin
				@(negedge clk);
				if (ring_valid !== 1'b0)
					seen = 1'b1;
			end
		join
		chk_bit(seen, 1'b0);
	endtask

	// ring end ex ticks after the call, valid dropped with it
	task automatic wait_end(input int ex);
		int t;
		t = 0;
		while (ring_end !== 1'b1 && t < (ex + 9) * TC) begin
			@(negedge clk);
			t++;
		end
		chk_span(t, (ex - 2) * TC, (ex + 2) * TC);
		@(negedge clk);
		chk_bit(ring_valid, 1'b0);
	endtask

	// ==========================================================
	// scenarios
	task automatic s_regs;
		logic [7:0] b;
		rd(8'h16, b);
		chk_byte(b, 8'h00);
		rd(8'h17, b);
		chk_byte(b, 8'h2d);
		rd(8'h18, b);
		chk_byte(b, 8'h19);
		wr(8'h18, 8'h59);
		rd(8'h18, b);
		chk_byte(b, 8'h19);
		wr(8'h33, 8'hff);
		rd(8'h33, b);
		chk_byte(b, 8'h00);
		// status: idle state code, mode bit on top; writes are ignored
		rd(8'h40, b);
		chk_byte(b, 8'h01);
		low_power = 1'b1;
		wr(8'h40, 8'h00);
		rd(8'h40, b);
		chk_byte(b, 8'h81);
		low_power = 1'b0;
	endtask

	// validation off: crossing shows at once, timeout scales per code
	task automatic s_bypass;
		int tc[4] = '{1, 2, 3, 15};
		wr(8'h18, 8'h14);
		for (int i = 0; i < 4; i++) begin
			wr(8'h17, {1'b0, 4'(tc[i]), 3'h0});
			rvt_line_model_i.burst(1, 1);
			@(negedge clk);
			chk_bit(ring_valid, 1'b1);
			wait_end(tc[i] * 64);
		end
	endtask

	// every confirmation code with 15-tick spacing, inside 10..19 ticks
	task automatic s_confirm;
		int ct[8] = '{50, 75, 100, 128, 192, 256, 320, 512};
		wr(8'h18, 8'h94);
		wr(8'h16, 8'h0a);
		for (int c = 0; c < 8; c++) begin
			low_power = (c == 7);
			wr(8'h17, {1'b0, 4'h1, 3'(c)});
			run_valid(ct[c] / 15 + 3, 15, ct[c]);
			wait_end(64);
		end
		low_power = 1'b0;
	endtask

	// delay code split across two registers
	task automatic s_delay;
		logic [2:0] dl[3] = '{3'h1, 3'h2, 3'h7};
		int ex;
		for (int i = 0; i < 3; i++) begin
			ex = 50 + int'(dl[i]) * 128;
			wr(8'h16, {dl[i][1:0], 6'h0a});
			wr(8'h17, {dl[i][2], 4'h1, 3'h0});
			run_valid(ex / 15 + 3, 15, ex);
			wait_end(64);
		end
	endtask

	// too fast, too slow, then a fast crossing dropping a valid ring
	task automatic s_invalid;
		wr(8'h16, 8'h0a);
		wr(8'h17, 8'h08);
		run_none(10, 8);
		wait_end(64 - 8);
		run_none(7, 22);
		wait_end(64 - 22);
		run_valid(6, 15, 50);
		repeat (3 * TC) @(negedge clk);
		rvt_line_model_i.burst(1, 1);
		repeat (3) @(negedge clk);
		chk_bit(ring_valid, 1'b0);
		wait_end(64);
	endtask

	// ==========================================================
	// verdict, reached from the main sequence or the watchdog
	task automatic summarize;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence; reset spans 12 clocks
	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
		low_power = 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		s_regs();
		s_bypass();
		s_confirm();
		s_delay();
		s_invalid();
		summarize();
	end

	// watchdog well beyond the roughly 60k clocks the scenarios need
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		$display("Error %0t: watchdog expired", $time);
		summarize();
	end
endmodule
`default_nettype wire
